// ==== alert_mask_defs.vh ====
// Constants for the status alert mask block: command and status codes,
// mask field positions, implemented-bit patterns and reset values.
// Included by bare name from every design file of the block.
`ifndef ALERT_MASK_DEFS_VH
`define ALERT_MASK_DEFS_VH

// Shared command code that reaches every alert mask
`define CMD_ALERT_MASK 8'h1B

// Status register codes, used as the mask selector byte
`define CODE_STATUS_VOUT 8'h7A
`define CODE_STATUS_IOUT 8'h7B
`define CODE_STATUS_INPUT 8'h7C
`define CODE_STATUS_TEMP 8'h7D
`define CODE_STATUS_CML 8'h7E
`define CODE_STATUS_OTHER 8'h7F
`define CODE_STATUS_VENDOR 8'h80

// Output-voltage mask field positions
`define BIT_VOUT_OV_FAULT 7
`define BIT_VOUT_OV_WARN 6
`define BIT_VOUT_UV_WARN 5
`define BIT_VOUT_UV_FAULT 4
`define BIT_VOUT_MAX_WARN 3
`define BIT_VOUT_TON_MAX_FAULT 2
`define BIT_VOUT_TOFF_MAX_WARN 1

// Output-current mask field positions
`define BIT_IOUT_OC_FAULT 7
`define BIT_IOUT_OC_LV_FAULT 6
`define BIT_IOUT_OC_WARN 5
`define BIT_IOUT_UC_FAULT 4

// Input mask field positions
`define BIT_VIN_OV_FAULT 7
`define BIT_VIN_OV_WARN 6
`define BIT_VIN_UV_WARN 5
`define BIT_VIN_UV_FAULT 4
`define BIT_VIN_INSUFFICIENT 3

// Temperature mask field positions
`define BIT_OT_FAULT 7
`define BIT_OT_WARN 6
`define BIT_UT_WARN 5
`define BIT_UT_FAULT 4

// Communication / memory / logic mask field positions
`define BIT_CML_BAD_CMD 7
`define BIT_CML_BAD_DATA 6
`define BIT_CML_PEC_FAIL 5
`define BIT_CML_MEM_FAULT 4
`define BIT_CML_CPU_FAULT 3
`define BIT_CML_OTHER_COMM 1
`define BIT_CML_MEM_LOGIC 0

// Other-status mask field position
`define BIT_OTHER_FLAG 0

// Vendor-specific mask field positions
`define BIT_VND_SYNC_FAULT 7
`define BIT_VND_AVG_OC 6
`define BIT_VND_FAST_OC 5
`define BIT_VND_SHORT 4
`define BIT_VND_OT2_FAULT 3
`define BIT_VND_AUX_FAULT 2
`define BIT_VND_STARTUP_OC 1
`define BIT_VND_OT2_WARN 0

// Bits of each status byte that carry a listed condition
`define VALID_VOUT 8'hFE
`define VALID_IOUT 8'hF0
`define VALID_INPUT 8'hF8
`define VALID_TEMP 8'hF0
`define VALID_CML 8'hFB
`define VALID_OTHER 8'h01
`define VALID_VENDOR 8'hFF

// Reset value of every mask: all conditions may pull the alert line
`define MASK_RESET 8'h00

// Byte returned on a read with no mask selected
`define READ_IDLE_BYTE 8'hFF

`endif

// ==== alert_mask_bank.v ====
// One alert mask byte with its gating of one status byte.
// Assumes writes arrive already decoded; status is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_defs.vh"

module alert_mask_bank #(
  parameter [7:0] VALID = 8'hFF
) (
  // Clock, reset, enable
  input wire clk,
  input wire nrst,
  input wire ce,
  // Mask write
  input wire wr_en,
  input wire [7:0] wr_data,
  // Status byte and results
  input wire [7:0] status,
  output wire [7:0] mask_q,
  output wire pending
);

  reg [7:0] mask_r;

  // Mask storage; all eight bits read back as written
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_r <= `MASK_RESET;
    end else if (ce && wr_en) begin
      mask_r <= wr_data;
    end
  end

  assign mask_q = mask_r;

  // A set status bit inside VALID with a clear mask bit is pending [R1] [R10]
  assign pending = |(status & ~mask_r & VALID);

endmodule
`default_nettype wire

// ==== alert_mask_logic.v ====
// Alert masking for the status registers of a power converter's
// management interface, with the mask command decoder and the alert pin.
// Assumes a bus engine that hands over received bytes of each transaction
// in order (command code first) and asks for read bytes one at a time;
// status bytes come from the status logic, synchronous to clk.
//
// Functional notes
// (R1) A clear mask bit lets its status condition pull the alert line, a set bit blocks it.
// (R2) The output-voltage mask, status 0x7A, gates OV/UV faults and warnings, max, ton, toff.
// (R3) The output-current mask, status 0x7B, gates overcurrent, OC low-V, OC warn, undercurrent.
// (R4) The input mask, status 0x7C, gates input OV/UV faults and warnings and low input.
// (R5) The temperature mask, status 0x7D, gates over and under temperature faults and warnings.
// (R6) The comm/logic mask, status 0x7E, gates bits 7 to 3, 1 and 0 of that status byte.
// (R7) The other-status mask, status 0x7F, gates its one condition at bit 0.
// (R8) The vendor-specific mask, status 0x80, gates all eight vendor conditions.
// (R9) After command 0x1B the first data byte picks the mask by status code, then the mask byte.
// (R10) The alert line stays pulled while any set status bit that carries a listed condition has a clear mask bit.
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_defs.vh"

module alert_mask_logic (
  // Clock, reset, enable
  input wire clk,
  input wire nrst,
  input wire ce,
  // Received transaction bytes
  input wire frame_start,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  // Read byte request and answer
  input wire rd_req,
  output reg tx_valid,
  output reg [7:0] tx_byte,
  // Transaction outcome strobes
  output reg mask_written,
  output reg sel_error,
  // Status bytes
  input wire [7:0] status_vout,
  input wire [7:0] status_iout,
  input wire [7:0] status_input,
  input wire [7:0] status_temp,
  input wire [7:0] status_cml,
  input wire [7:0] status_other,
  input wire [7:0] status_vendor,
  // Alert line, open drain, active low, and an active-high alert flag
  output reg fault_alert_line_o,
  output reg fault_alert_line_oe,
  output reg alert_active
);

  // Number of masks behind the shared command
  localparam NCH = 7;

  // Transaction states, one-hot
  localparam [3:0] ST_CMD = 4'h1;
  localparam [3:0] ST_SEL = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_SKIP = 4'h8;

  // Selector codes per channel, channel 0 in the low byte
  localparam [8*NCH-1:0] CODES = {
    `CODE_STATUS_VENDOR,
    `CODE_STATUS_OTHER,
    `CODE_STATUS_CML,
    `CODE_STATUS_TEMP,
    `CODE_STATUS_INPUT,
    `CODE_STATUS_IOUT,
    `CODE_STATUS_VOUT
  };

  // Output-voltage conditions; bit 0 has none and never alerts
  localparam [7:0] VLD_VOUT = // [R2]
    (8'h01 << `BIT_VOUT_OV_FAULT) |
    (8'h01 << `BIT_VOUT_OV_WARN) |
    (8'h01 << `BIT_VOUT_UV_WARN) |
    (8'h01 << `BIT_VOUT_UV_FAULT) |
    (8'h01 << `BIT_VOUT_MAX_WARN) |
    (8'h01 << `BIT_VOUT_TON_MAX_FAULT) |
    (8'h01 << `BIT_VOUT_TOFF_MAX_WARN);

  // Output-current conditions in the upper nibble only
  localparam [7:0] VLD_IOUT = // [R3]
    (8'h01 << `BIT_IOUT_OC_FAULT) |
    (8'h01 << `BIT_IOUT_OC_LV_FAULT) |
    (8'h01 << `BIT_IOUT_OC_WARN) |
    (8'h01 << `BIT_IOUT_UC_FAULT);

  // Input conditions, bits 7 down to 3
  localparam [7:0] VLD_INPUT = // [R4]
    (8'h01 << `BIT_VIN_OV_FAULT) |
    (8'h01 << `BIT_VIN_OV_WARN) |
    (8'h01 << `BIT_VIN_UV_WARN) |
    (8'h01 << `BIT_VIN_UV_FAULT) |
    (8'h01 << `BIT_VIN_INSUFFICIENT);

  // Temperature conditions in the upper nibble only
  localparam [7:0] VLD_TEMP = // [R5]
    (8'h01 << `BIT_OT_FAULT) |
    (8'h01 << `BIT_OT_WARN) |
    (8'h01 << `BIT_UT_WARN) |
    (8'h01 << `BIT_UT_FAULT);

  // Communication and logic conditions; bit 2 has none
  localparam [7:0] VLD_CML = // [R6]
    (8'h01 << `BIT_CML_BAD_CMD) |
    (8'h01 << `BIT_CML_BAD_DATA) |
    (8'h01 << `BIT_CML_PEC_FAIL) |
    (8'h01 << `BIT_CML_MEM_FAULT) |
    (8'h01 << `BIT_CML_CPU_FAULT) |
    (8'h01 << `BIT_CML_OTHER_COMM) |
    (8'h01 << `BIT_CML_MEM_LOGIC);

  // Other status: a single condition
  localparam [7:0] VLD_OTHER = // [R7]
    (8'h01 << `BIT_OTHER_FLAG);

  // Vendor-specific conditions fill the whole byte
  localparam [7:0] VLD_VENDOR = // [R8]
    (8'h01 << `BIT_VND_SYNC_FAULT) |
    (8'h01 << `BIT_VND_AVG_OC) |
    (8'h01 << `BIT_VND_FAST_OC) |
    (8'h01 << `BIT_VND_SHORT) |
    (8'h01 << `BIT_VND_OT2_FAULT) |
    (8'h01 << `BIT_VND_AUX_FAULT) |
    (8'h01 << `BIT_VND_STARTUP_OC) |
    (8'h01 << `BIT_VND_OT2_WARN);

  // Implemented condition bits per channel, channel 0 in the low byte
  localparam [8*NCH-1:0] VALIDS = {
    VLD_VENDOR,
    VLD_OTHER,
    VLD_CML,
    VLD_TEMP,
    VLD_INPUT,
    VLD_IOUT,
    VLD_VOUT
  };

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [2:0] sel_r;
  reg [2:0] sel_nxt;
  reg sel_hit;
  reg [2:0] sel_idx;
  reg wr_go;
  reg err_go;
  reg [7:0] rd_byte;
  integer i;

  wire [8*NCH-1:0] status_all;
  wire [8*NCH-1:0] mask_all;
  wire [NCH-1:0] pending;
  wire [NCH-1:0] wr_sel;
  wire [7:0] output_voltage_alert_mask;
  wire [7:0] output_current_alert_mask;
  wire [7:0] input_alert_mask;
  wire [7:0] temperature_alert_mask;
  wire [7:0] comm_logic_alert_mask;
  wire [7:0] other_alert_mask;
  wire [7:0] vendor_status_alert_mask;

  // Named views of the seven stored masks, in channel order
  assign output_voltage_alert_mask = mask_all[7:0];
  assign output_current_alert_mask = mask_all[15:8];
  assign input_alert_mask = mask_all[23:16];
  assign temperature_alert_mask = mask_all[31:24];
  assign comm_logic_alert_mask = mask_all[39:32];
  assign other_alert_mask = mask_all[47:40];
  assign vendor_status_alert_mask = mask_all[55:48];

  // Status bytes in channel order, matching CODES
  assign status_all = {
    status_vendor,
    status_other,
    status_cml,
    status_temp,
    status_input,
    status_iout,
    status_vout
  };

  // Match the selector byte against the status codes
  always @* begin
    sel_hit = 1'b0;
    sel_idx = 3'h0;
    for (i = 0; i < NCH; i = i + 1) begin
      if (rx_byte == CODES[8*i +: 8]) begin
        sel_hit = 1'b1;
        sel_idx = i[2:0];
      end
    end
  end

  // Transaction sequencing: command, selector, then mask byte
  always @* begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    wr_go = 1'b0;
    err_go = 1'b0;
    if (frame_start) begin
      state_nxt = ST_CMD;
    end else if (rx_valid) begin
      case (state_r)
        ST_CMD: begin
          if (rx_byte == `CMD_ALERT_MASK) begin
            state_nxt = ST_SEL;
          end else begin
            state_nxt = ST_SKIP;
          end
        end
        ST_SEL: begin
          if (sel_hit) begin
            sel_nxt = sel_idx; // [R9]
            state_nxt = ST_DATA;
          end else begin
            err_go = 1'b1;
            state_nxt = ST_SKIP;
          end
        end
        ST_DATA: begin
          wr_go = 1'b1; // [R9]
          state_nxt = ST_SKIP;
        end
        ST_SKIP: begin
          state_nxt = ST_SKIP;
        end
        default: begin
          state_nxt = ST_SKIP;
        end
      endcase
    end
  end

  // State and selection registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_SKIP;
      sel_r <= 3'h0;
    end else if (ce) begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Write strobe for the selected mask only
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chan
      assign wr_sel[g] = wr_go && (sel_r == g);
      // One mask per status register [R2] [R3] [R4] [R5] [R6] [R7] [R8]
      alert_mask_bank #(
        .VALID(VALIDS[8*g +: 8])
      ) u_bank (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .wr_en(wr_sel[g]),
        .wr_data(rx_byte),
        .status(status_all[8*g +: 8]),
        .mask_q(mask_all[8*g +: 8]),
        .pending(pending[g])
      );
    end
  endgenerate

  // Read data: the selected mask after a selector was accepted, until the mask byte arrives
  always @* begin
    if (state_r != ST_DATA) begin
      rd_byte = `READ_IDLE_BYTE;
    end else if (sel_r == 3'h0) begin
      rd_byte = output_voltage_alert_mask; // [R9]
    end else if (sel_r == 3'h1) begin
      rd_byte = output_current_alert_mask;
    end else if (sel_r == 3'h2) begin
      rd_byte = input_alert_mask;
    end else if (sel_r == 3'h3) begin
      rd_byte = temperature_alert_mask;
    end else if (sel_r == 3'h4) begin
      rd_byte = comm_logic_alert_mask;
    end else if (sel_r == 3'h5) begin
      rd_byte = other_alert_mask;
    end else begin
      rd_byte = vendor_status_alert_mask; // Only code 6 reaches here
    end
  end

  // Read answer and transaction strobes, one cycle each
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      mask_written <= 1'b0;
      sel_error <= 1'b0;
    end else if (ce) begin
      tx_valid <= rd_req;
      if (rd_req) begin
        tx_byte <= rd_byte;
      end
      mask_written <= wr_go;
      sel_error <= err_go;
    end
  end

  // Alert line: pulled low while any unmasked condition is set
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alert_active <= 1'b0;
      fault_alert_line_oe <= 1'b0;
      fault_alert_line_o <= 1'b0;
    end else if (ce) begin
      alert_active <= |pending; // [R10]
      fault_alert_line_oe <= |pending; // [R1] [R10]
      fault_alert_line_o <= 1'b0; // Open drain only ever drives low
    end
  end

endmodule
`default_nettype wire

// ==== alert_mask_checker.sv ====
// Checker for alert_mask_logic: read timing, strobes, alert pin.
// Bound below onto the design top; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
module alert_mask_checker (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Byte port
  input wire logic rd_req,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic mask_written,
  input wire logic sel_error,
  // Alert pin
  input wire logic fault_alert_line_o,
  input wire logic fault_alert_line_oe,
  input wire logic alert_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rd; rd_req && ce |=> tx_valid; endproperty
  a_rd: assert property (p_rd) else $error("no read reply");
  property p_one; ce && !rd_req |=> !tx_valid && $stable(tx_byte); endproperty
  a_one: assert property (p_one) else $error("read port moved");
  property p_wr; mask_written && ce |=> !mask_written; endproperty
  a_wr: assert property (p_wr) else $error("write strobe long");
  property p_err; sel_error && ce |=> !sel_error; endproperty
  a_err: assert property (p_err) else $error("error strobe long");
  property p_excl; !(mask_written && sel_error); endproperty
  a_excl: assert property (p_excl) else $error("both strobes");
  property p_od; fault_alert_line_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("alert pin high");
  property p_same; alert_active == fault_alert_line_oe; endproperty
  a_same: assert property (p_same) else $error("alert flags differ");
  property p_frz; !ce |=> $stable(alert_active) && $stable(tx_byte); endproperty
  a_frz: assert property (p_frz) else $error("frozen state moved");
  c_rd: cover property (rd_req && ce);
  c_wr: cover property (mask_written);
  c_err: cover property (sel_error);
  c_alert: cover property (fault_alert_line_oe);
endmodule
bind alert_mask_logic alert_mask_checker chk (.*);
`default_nettype wire

// ==== alert_host_model.sv ====
// Host model: mask frames and read strobes, driven 1 ns after clk rises.
`timescale 1ns/1ps
`default_nettype none
module alert_host_model (
  // Clock
  input wire logic clk,
  // Requests
  output logic fs = 1'b0,
  output logic rv = 1'b0,
  output logic [7:0] rb = 8'h00,
  output logic rr = 1'b0,
  // Answers
  input wire logic tv,
  input wire logic [7:0] tb,
  input wire logic mw,
  input wire logic se
);
  logic wr_seen, err_seen;
  // Start, then n of c, s, v; a slow host idles gap cycles before each byte after the first
  task automatic frame(input logic [7:0] c, s, v, input int n, input int gap);
    logic [7:0] b [3];
    b = '{c, s, v};
    @(posedge clk);
    #1;
    fs = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      fs = 1'b0;
      if (i > 0 && gap > 0) begin
        rv = 1'b0;
        rb = ~rb;
        repeat (gap) @(posedge clk);
        #1;
      end
      rv = 1'b1;
      rb = b[i];
    end
    @(posedge clk);
    #1;
    rv = 1'b0;
    rb = ~rb;
    wr_seen = mw;
    err_seen = se;
  endtask
  // One read strobe; the reply is due one edge later
  task automatic read(output logic [7:0] d);
    @(posedge clk);
    #1;
    rr = 1'b1;
    @(posedge clk);
    #1;
    rr = 1'b0;
    d = tv ? tb : 8'hXX;
  endtask
endmodule
`default_nettype wire

// ==== alert_mask_logic_tb.sv ====
// Bench for alert_mask_logic: per-bit masking, reads, refusals, freeze.
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_defs.vh"
module alert_mask_logic_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [7:0] st [7] = '{default: 8'h00};
  logic [7:0] valid [7] = '{`VALID_VOUT, `VALID_IOUT, `VALID_INPUT, `VALID_TEMP, `VALID_CML,
    `VALID_OTHER, `VALID_VENDOR};
  logic [7:0] d;
  wire logic fs, rv, rr, tv, mw, se, alert, od, oe;
  wire logic [7:0] rb, tb;
  int fail_count, comparisons, cycles;
  alert_mask_logic dut (.clk(clk), .nrst(nrst), .ce(ce), .frame_start(fs), .rx_valid(rv),
    .rx_byte(rb), .rd_req(rr), .tx_valid(tv), .tx_byte(tb), .mask_written(mw),
    .sel_error(se), .status_vout(st[0]), .status_iout(st[1]), .status_input(st[2]),
    .status_temp(st[3]), .status_cml(st[4]), .status_other(st[5]), .status_vendor(st[6]),
    .fault_alert_line_o(od), .fault_alert_line_oe(oe), .alert_active(alert));
  alert_host_model host (.clk(clk), .fs(fs), .rv(rv), .rb(rb), .rr(rr), .tv(tv), .tb(tb),
    .mw(mw), .se(se));
  // Clock, 5 ns period
  initial forever #2.5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Alert one edge after its cause
  task automatic alert_is(input logic e);
    @(posedge clk);
    #1;
    chk(alert, e);
    chk(oe, e);
    chk(od, 1'b0);
  endtask
  // Each channel: reset mask, then each status bit against its mask bit
  task automatic t_map;
    for (int i = 0; i < 7; i++) begin
      host.frame(8'h1B, 8'h7A + 8'(i), 8'h00, 2, 0);
      host.read(d);
      chk(d, `MASK_RESET);
      for (int b = 0; b < 8; b++) begin
        st[i] = 8'h01 << b;
        host.frame(8'h1B, 8'h7A + 8'(i), ~st[i], 3, b % 2);
        chk(host.wr_seen, 1'b1);
        alert_is(valid[i][b]);
        host.frame(8'h1B, 8'h7A + 8'(i), st[i], 3, 0);
        alert_is(1'b0);
      end
      st[i] = 8'h00;
    end
  endtask
  // Refused frames, closed read window, frozen enable
  task automatic t_bad;
    host.frame(8'h1C, 8'h7A, 8'h00, 3, 0);
    chk(host.wr_seen, 1'b0);
    host.frame(8'h1B, 8'h79, 8'h00, 2, 0);
    chk(host.err_seen, 1'b1);
    host.read(d);
    chk(d, `READ_IDLE_BYTE);
    host.frame(8'h1B, 8'h7A, 8'h00, 2, 0);
    host.read(d);
    chk(d, 8'h80);
    host.frame(8'h1B, 8'h7A, 8'h00, 3, 0);
    st[0] = 8'h80;
    alert_is(1'b1);
    host.read(d);
    chk(d, `READ_IDLE_BYTE);
    ce = 1'b0;
    st[0] = 8'h00;
    repeat (3) @(posedge clk);
    alert_is(1'b1);
    ce = 1'b1;
    alert_is(1'b0);
  endtask
  // Reset for 3 cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_map();
    t_bad();
    end_of_test();
  end
endmodule
`default_nettype wire
